// ===== logic/pcd_pkg.sv
// Package: constants, enums and structs for the port C/D function multiplexer
package pcd_pkg;

    // ------------------------------------------------------------
    // Widths and pin positions
    // ------------------------------------------------------------
    localparam int PCD_PORT_W = 8;
    localparam int PCD_NIB_W = 4;
    localparam int PCD_ADDR_W = 16;
    localparam int PCD_PD_W = 3;
    localparam int PCD_PIN_RDY = 3;
    localparam int PCD_PIN_TEST_STATUS_OUT = 3;
    localparam int PCD_PIN_TEST_ERROR_OUT = 4;
    localparam int PCD_PIN_BATT = 4;
    localparam int PCD_PIN_TDI = 5;
    localparam int PCD_PIN_TDO = 6;
    localparam int PCD_PIN_DBE = 7;
    localparam int PCD_PIN_ALE = 0;
    localparam int PCD_PIN_CLK = 1;
    localparam int PCD_PIN_CSI = 2;

    // ------------------------------------------------------------
    // Reset values and address slices
    // ------------------------------------------------------------
    localparam logic [PCD_ADDR_W-1:0] PCD_ADDR_RST = 16'h0000;
    localparam logic [PCD_PORT_W-1:0] PCD_BYTE_ZERO = 8'h00;
    localparam int PCD_A_LO = 0;
    localparam int PCD_A_HI = 4;
    localparam int PCD_A_P2 = 8;
    localparam int PCD_A_P3 = 12;

    // ------------------------------------------------------------
    // Function selects
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PCD_FN_MCU = 3'b000,    // Host-controlled I/O
        PCD_FN_MCELL = 3'b001,  // Macrocell / logic output
        PCD_FN_PLDIN = 3'b010,  // Input to logic arrays
        PCD_FN_TEST = 3'b011,   // Boundary-scan line
        PCD_FN_SPECIAL = 3'b100 // Ready-busy, battery, strobe, clock, chip select
    } pcd_fn_e;

    typedef enum logic [1:0] {
        PCD_HOST_MUX = 2'b00,   // Generic multiplexed 8-bit
        PCD_HOST_NMUX = 2'b01,  // Non-multiplexed 8-bit
        PCD_HOST_EXT = 2'b10,   // Extended-architecture 8-bit
        PCD_HOST_PAGE = 2'b11   // Page-mode host
    } pcd_host_e;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PCD_PORT_W-1:0] dout;
        logic [PCD_PORT_W-1:0] oe;
    } pcd_drive_s;

    typedef struct packed {
        logic [PCD_PORT_W-1:0] oeA;
        logic [PCD_PORT_W-1:0] valA;
        logic [PCD_PORT_W-1:0] oeB;
        logic [PCD_PORT_W-1:0] valB;
    } pcd_addrout_s;

endpackage

// ===== logic/pcd_addr_latch.sv
// Address latch with port A/B latched address output mapping
`timescale 1ns/1ps
module pcd_addr_latch
    import pcd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Capture
    input wire logic strobe,
    input wire logic [PCD_ADDR_W-1:0] addrIn,
    input wire logic isMux,
    // Mapping
    input wire pcd_host_e hostMode,
    output pcd_addrout_s addrOut
);

    logic [PCD_ADDR_W-1:0] addr_r;

    // ------------------------------------------------------------
    // Latch
    // ------------------------------------------------------------
    // transparent capture, hold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_r <= PCD_ADDR_RST;
        end else if (strobe || !isMux) begin
            addr_r <= addrIn;
        end
    end

    // ------------------------------------------------------------
    // Nibble mapping, registered so data leaves from flip-flops
    // ------------------------------------------------------------
    function automatic logic [PCD_NIB_W-1:0] nib(input logic [PCD_ADDR_W-1:0] a, input int lo);
        nib = a[lo +: PCD_NIB_W];
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addrOut <= '0;
        end else begin
            addrOut <= '0;
            case (hostMode)
                PCD_HOST_MUX: begin
                    addrOut.oeA <= {PCD_PORT_W{1'b1}};
                    addrOut.valA <= {nib(addr_r, PCD_A_HI), nib(addr_r, PCD_A_LO)};
                    addrOut.oeB <= {PCD_PORT_W{1'b1}};
                    addrOut.valB <= {nib(addr_r, PCD_A_HI), nib(addr_r, PCD_A_LO)};
                end
                PCD_HOST_NMUX: begin
                    addrOut.oeB <= {PCD_PORT_W{1'b1}};
                    addrOut.valB <= {nib(addr_r, PCD_A_HI), nib(addr_r, PCD_A_LO)};
                end
                PCD_HOST_EXT: begin
                    addrOut.oeA <= {{PCD_NIB_W{1'b1}}, {PCD_NIB_W{1'b0}}};
                    addrOut.valA <= {nib(addr_r, PCD_A_HI), {PCD_NIB_W{1'b0}}};
                    addrOut.oeB <= {{PCD_NIB_W{1'b0}}, {PCD_NIB_W{1'b1}}};
                    addrOut.valB <= {{PCD_NIB_W{1'b0}}, nib(addr_r, PCD_A_P2)};
                end
                PCD_HOST_PAGE: begin
                    addrOut.oeB <= {PCD_PORT_W{1'b1}};
                    addrOut.valB <= {nib(addr_r, PCD_A_P3), nib(addr_r, PCD_A_P2)};
                end
                default: begin
                    addrOut <= '0;
                end
            endcase
        end
    end

endmodule

// ===== logic/pcd_port_mux.sv
// Port C and port D pin function multiplexer with latched address output
`timescale 1ns/1ps
// Contract
// - Each port C pin selects host I/O, macrocell output or logic-array input.
// - Each port C output can be push-pull or open-drain.
// - Test data in on C5, test data out on C6, test status on C3, test error on C4.
// - Port C pin 3 can present the flash ready-busy status.
// - Ready-busy drives 0 while a flash write or erase runs; otherwise push-pull drives 1 and open-drain lets go.
// - With the battery function on C4, the pin is high while on backup battery.
// - Port D pin 0 can be the address-latch strobe that captures the host address.
// - Port D pin 1 can be the logic clock for macrocells, power-down counter and array.
// - Chip select on D2 is active low; while high the memory blocks are disabled.
// - Port D pins 0 to 2 also select host I/O, logic input or logic-made chip select.
// - Multiplexed hosts get address nibbles on A and B (page host on B only), non-multiplexed only on B.
// - Extended host maps [7:4] to A high and [11:8] to B low; page host [15:8] to B.
module pcd_port_mux
    import pcd_pkg::*;
#(
    parameter int PORT_W = PCD_PORT_W,
    parameter int PD_W = PCD_PD_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Port C configuration
    input wire pcd_fn_e [PORT_W-1:0] pcFunc,
    input wire logic [PORT_W-1:0] pcOpenDrain,
    input wire logic [PORT_W-1:0] pcHostDir,
    input wire logic [PORT_W-1:0] pcHostOut,
    // Port D configuration
    input wire pcd_fn_e [PD_W-1:0] pdFunc,
    input wire logic [PD_W-1:0] pdHostDir,
    input wire logic [PD_W-1:0] pdHostOut,
    // Address output configuration
    input wire pcd_host_e hostMode,
    input wire logic [PORT_W-1:0] paAddrSel,
    input wire logic [PORT_W-1:0] pbAddrSel,
    input wire logic [PCD_ADDR_W-1:0] hostAddr,
    // Internal sources
    input wire logic [PORT_W-1:0] macrocell_output_group2,
    input wire logic [PD_W-1:0] logicChipSel,
    input wire logic flashBusy,
    input wire logic onBattery,
    input wire logic test_status_out,
    input wire logic test_error_out,
    input wire logic testDataOut,
    input wire logic testDataOutEn,
    // Port C pins
    input wire logic [PORT_W-1:0] pcIn,
    output logic [PORT_W-1:0] pcOut,
    output logic [PORT_W-1:0] pcOe,
    // Port D pins
    input wire logic [PD_W-1:0] pdIn,
    output logic [PD_W-1:0] pdOut,
    output logic [PD_W-1:0] pdOe,
    // Port A and B latched address drive
    output pcd_addrout_s addrDrive,
    // Results toward host and logic
    output logic [PORT_W-1:0] pcHostRead,
    output logic [PD_W-1:0] pdHostRead,
    output logic [PORT_W-1:0] pcLogicIn,
    output logic [PD_W-1:0] pdLogicIn,
    output logic testDataIn,
    output logic byte_enable_in_n,
    output logic byteValid,
    output logic address_latch_strobe,
    output logic logic_clock_in,
    output logic memEnable
);

    pcd_drive_s pcDrv;
    pcd_drive_s pcDrv_r;
    logic [PD_W-1:0] pdOutNxt;
    logic [PD_W-1:0] pdOeNxt;
    logic [PD_W-1:0] pdOut_r;
    logic [PD_W-1:0] pdOe_r;

    // ------------------------------------------------------------
    // Port C source selection
    // ------------------------------------------------------------
    // per-pin source
    always_comb begin
        pcDrv = '0;
        for (int i = 0; i < PORT_W; i++) begin
            case (pcFunc[i])
                PCD_FN_MCU: begin
                    pcDrv.dout[i] = pcHostOut[i];
                    pcDrv.oe[i] = pcHostDir[i];
                end
                PCD_FN_MCELL: begin
                    pcDrv.dout[i] = macrocell_output_group2[i];
                    pcDrv.oe[i] = 1'b1;
                end
                PCD_FN_TEST: begin
                    // Test status and error drive; data out follows its own enable
                    if (i == PCD_PIN_TEST_STATUS_OUT) begin
                        pcDrv.dout[i] = test_status_out;
                        pcDrv.oe[i] = 1'b1;
                    end else if (i == PCD_PIN_TEST_ERROR_OUT) begin
                        pcDrv.dout[i] = test_error_out;
                        pcDrv.oe[i] = 1'b1;
                    end else if (i == PCD_PIN_TDO) begin
                        pcDrv.dout[i] = testDataOut;
                        pcDrv.oe[i] = testDataOutEn;
                    end
                end
                PCD_FN_SPECIAL: begin
                    if (i == PCD_PIN_RDY) begin
                        pcDrv.dout[i] = !flashBusy;
                        pcDrv.oe[i] = 1'b1;
                    end else if (i == PCD_PIN_BATT) begin
                        pcDrv.dout[i] = onBattery;
                        pcDrv.oe[i] = 1'b1;
                    end
                end
                default: begin
                    pcDrv.dout[i] = 1'b0;
                    pcDrv.oe[i] = 1'b0;
                end
            endcase
        end
    end

    // Pad registers so pin data comes from flip-flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pcDrv_r <= '0;
        end else begin
            pcDrv_r <= pcDrv;
        end
    end

    // ------------------------------------------------------------
    // Port C driver type
    // ------------------------------------------------------------
    // open-drain drives low only
    genvar g;
    generate
        for (g = 0; g < PORT_W; g++) begin : gPcDrv
            assign pcOut[g] = pcOpenDrain[g] ? 1'b0 : pcDrv_r.dout[g];
            assign pcOe[g] = pcDrv_r.oe[g] && (!pcOpenDrain[g] || !pcDrv_r.dout[g]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Port C inputs
    // ------------------------------------------------------------
    // host read and array input
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            pcHostRead[i] = pcIn[i];
            pcLogicIn[i] = (pcFunc[i] == PCD_FN_PLDIN) && pcIn[i];
        end
    end

    // test data in on pin 5
    assign testDataIn = (pcFunc[PCD_PIN_TDI] == PCD_FN_TEST) && pcIn[PCD_PIN_TDI];

    // byte enable, deselected reads inactive high
    assign byte_enable_in_n = (pcFunc[PCD_PIN_DBE] == PCD_FN_SPECIAL) ? pcIn[PCD_PIN_DBE] : 1'b1;
    assign byteValid = !byte_enable_in_n;

    // ------------------------------------------------------------
    // Port D
    // ------------------------------------------------------------
    // host I/O or logic chip select
    always_comb begin
        for (int i = 0; i < PD_W; i++) begin
            pdOutNxt[i] = 1'b0;
            pdOeNxt[i] = 1'b0;
            case (pdFunc[i])
                PCD_FN_MCU: begin
                    pdOutNxt[i] = pdHostOut[i];
                    pdOeNxt[i] = pdHostDir[i];
                end
                PCD_FN_MCELL: begin
                    pdOutNxt[i] = logicChipSel[i];
                    pdOeNxt[i] = 1'b1;
                end
                default: begin
                    pdOutNxt[i] = 1'b0;
                    pdOeNxt[i] = 1'b0;
                end
            endcase
            pdHostRead[i] = pdIn[i];
            pdLogicIn[i] = (pdFunc[i] == PCD_FN_PLDIN) && pdIn[i];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pdOut_r <= '0;
            pdOe_r <= '0;
        end else begin
            pdOut_r <= pdOutNxt;
            pdOe_r <= pdOeNxt;
        end
    end
    assign pdOut = pdOut_r;
    assign pdOe = pdOe_r;

    assign address_latch_strobe = (pdFunc[PCD_PIN_ALE] == PCD_FN_SPECIAL) && pdIn[PCD_PIN_ALE];
    // logic clock from pin 1; passed through unregistered, fans out to macrocells
    assign logic_clock_in = (pdFunc[PCD_PIN_CLK] == PCD_FN_SPECIAL) && pdIn[PCD_PIN_CLK];
    // chip select low enables memories; unused select leaves them on
    assign memEnable = (pdFunc[PCD_PIN_CSI] == PCD_FN_SPECIAL) ? !pdIn[PCD_PIN_CSI] : 1'b1;

    // ------------------------------------------------------------
    // Latched address output
    // ------------------------------------------------------------
    pcd_addrout_s addrMap;

    pcd_addr_latch uLatch (
        .clk(clk),
        .rst(rst),
        .strobe(address_latch_strobe),
        .addrIn(hostAddr),
        .isMux(hostMode != PCD_HOST_NMUX),
        .hostMode(hostMode),
        .addrOut(addrMap)
    );

    // only pins set to address mode drive it
    assign addrDrive.oeA = addrMap.oeA & paAddrSel;
    assign addrDrive.valA = addrMap.valA;
    assign addrDrive.oeB = addrMap.oeB & pbAddrSel;
    assign addrDrive.valB = addrMap.valB;

endmodule

// ===== bench/pcd_port_mux_asserts.sv
// Checker for the port C/D function multiplexer
`timescale 1ns/1ps
module pcd_port_mux_asserts
    import pcd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration and sources
    input wire pcd_fn_e [PCD_PORT_W-1:0] pcFunc,
    input wire logic [PCD_PORT_W-1:0] pcOpenDrain,
    input wire pcd_fn_e [PCD_PD_W-1:0] pdFunc,
    input wire pcd_host_e hostMode,
    input wire logic flashBusy,
    input wire logic onBattery,
    // Pins and results
    input wire logic [PCD_PORT_W-1:0] pcIn,
    input wire logic [PCD_PD_W-1:0] pdIn,
    input wire logic [PCD_PORT_W-1:0] pcOut,
    input wire logic [PCD_PORT_W-1:0] pcOe,
    input wire pcd_addrout_s addrDrive,
    input wire logic testDataIn,
    input wire logic address_latch_strobe,
    input wire logic memEnable
);
    // ----------
    // Properties
    // ----------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // busy drives low
    // Driver type follows the live open-drain select, so test it on the check cycle
    property p_rdy;
        pcFunc[3] == PCD_FN_SPECIAL ##1 !pcOpenDrain[3]
            |-> pcOe[3] && pcOut[3] == !$past(flashBusy);
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready-busy pin wrong");
    property p_batt;
        pcFunc[4] == PCD_FN_SPECIAL ##1 !pcOpenDrain[4]
            |-> pcOe[4] && pcOut[4] == $past(onBattery);
    endproperty
    a_batt: assert property (p_batt) else $error("battery pin wrong");
    property p_od; (pcOe & pcOut & pcOpenDrain) == 8'h00; endproperty
    a_od: assert property (p_od) else $error("open-drain pin driven high");
    property p_tdi; testDataIn == (pcIn[5] && pcFunc[5] == PCD_FN_TEST); endproperty
    a_tdi: assert property (p_tdi) else $error("test input wrong");
    property p_cs; pdFunc[2] == PCD_FN_SPECIAL |-> memEnable == !pdIn[2]; endproperty
    a_cs: assert property (p_cs) else $error("memory enable wrong");
    property p_ale; address_latch_strobe == (pdIn[0] && pdFunc[0] == PCD_FN_SPECIAL); endproperty
    a_ale: assert property (p_ale) else $error("strobe decode wrong");
    property p_hold;
        (!address_latch_strobe && hostMode == PCD_HOST_MUX) [*3] |=> $stable(addrDrive.valB);
    endproperty
    a_hold: assert property (p_hold) else $error("latched address moved");
    // no port A drive when non-multiplexed
    property p_nmux; (hostMode == PCD_HOST_NMUX) [*2] |-> addrDrive.oeA == 8'h00; endproperty
    a_nmux: assert property (p_nmux) else $error("port A driven");
    // Main scenarios reached
    c_strobe: cover property (address_latch_strobe);
    c_busy: cover property (pcFunc[3] == PCD_FN_SPECIAL && flashBusy);
    c_cs: cover property (memEnable && pdFunc[2] == PCD_FN_SPECIAL);
endmodule

bind pcd_port_mux pcd_port_mux_asserts u_chk (.*);

// ===== bench/pcd_host_model.sv
// Host bus partner: address strobe, chip select and byte enable
`timescale 1ns/1ps
module pcd_host_model
    import pcd_pkg::*;
(
    // Clock
    input wire logic clk,
    // Bus toward the device
    output logic [PCD_ADDR_W-1:0] hostAddr,
    output logic addrStrobe,
    output logic csN,
    output logic byteEnN
);
    // Idle bus: strobe low, both selects high
    initial begin
        hostAddr = PCD_ADDR_RST;
        addrStrobe = 1'b0;
        csN = 1'b1;
        byteEnN = 1'b1;
    end
    task automatic addr_phase(input logic [PCD_ADDR_W-1:0] a, input logic keep);
        @(negedge clk);
        hostAddr = a;
        addrStrobe = 1'b1;
        @(negedge clk);
        addrStrobe = 1'b0;
        @(negedge clk);
        // Bus turns to data; unless keep is set, do not leave the old address showing
        if (!keep) begin
            hostAddr = ~a;
        end
    endtask
    task automatic set_sel(input logic cs, input logic be);
        @(negedge clk);
        csN = cs;
        byteEnN = be;
    endtask
endmodule

// ===== bench/pcd_port_mux_tb_top.sv
// Self-checking bench for the port C/D function multiplexer
`timescale 1ns/1ps
module pcd_port_mux_tb_top
    import pcd_pkg::*;
;
    // ----------
    // Signals
    // ----------
    logic clk;
    logic rst = 1'b1;
    pcd_fn_e [PCD_PORT_W-1:0] pcFunc;
    pcd_fn_e [PCD_PD_W-1:0] pdFunc;
    pcd_host_e hostMode = PCD_HOST_MUX;
    logic [7:0] pcOpenDrain = 8'h00, pcHostDir = 8'h00, pcHostOut = 8'h00;
    logic [7:0] paAddrSel = 8'hFF, pbAddrSel = 8'hFF, macrocell_output_group2 = 8'h00;
    logic [7:0] pcIn, pcOut, pcOe, pcHostRead, pcLogicIn;
    logic [6:0] pcPins = 7'h2A;
    logic [2:0] pdHostDir = 3'h0, pdHostOut = 3'h0, logicChipSel = 3'h0;
    logic [2:0] pdIn, pdOut, pdOe, pdHostRead, pdLogicIn;
    logic [15:0] hostAddr;
    logic flashBusy = 1'b0, onBattery = 1'b0, test_status_out = 1'b0, test_error_out = 1'b0;
    logic testDataOut = 1'b0, testDataOutEn = 1'b0, clkPin = 1'b0;
    logic testDataIn, byte_enable_in_n, byteValid, address_latch_strobe, logic_clock_in;
    logic memEnable, addrStrobe, csN, byteEnN;
    pcd_addrout_s addrDrive;
    int failures = 0;
    int cmp_count = 0;
    // Wire level: whoever enables its driver owns the pin
    assign pcIn = (pcOe & pcOut) | (~pcOe & {byteEnN, pcPins});
    assign pdIn = (pdOe & pdOut) | (~pdOe & {csN, clkPin, addrStrobe});
    pcd_port_mux dut (.*);
    pcd_host_model hm (.clk(clk), .hostAddr(hostAddr), .addrStrobe(addrStrobe), .csN(csN),
        .byteEnN(byteEnN));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ----------
    // Helpers
    // ----------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares=%0d mismatches=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic setf(input pcd_fn_e c, input pcd_fn_e d);
        foreach (pcFunc[i]) pcFunc[i] = c;
        foreach (pdFunc[i]) pdFunc[i] = d;
    endtask
    // ----------
    // Scenarios
    // ----------
    // port C general functions
    task automatic t_cfunc();
        pcHostDir = 8'hFF;
        pcHostOut = 8'hA5;
        tick(1);
        check({pcOe, pcOut}, 16'hFFA5);
        pcOpenDrain = 8'hFF;
        tick(1);
        check({pcOe, pcOut}, 16'h5A00);
        pcHostDir = 8'h00;
        tick(1);
        check({pcOe, pcHostRead}, {8'h00, pcIn});
        setf(PCD_FN_MCELL, PCD_FN_MCU);
        pcOpenDrain = 8'h00;
        macrocell_output_group2 = 8'h3C;
        tick(1);
        check({pcOe, pcOut}, 16'hFF3C);
        setf(PCD_FN_PLDIN, PCD_FN_MCU);
        tick(1);
        check({pcOe, pcLogicIn}, {8'h00, pcIn});
        $display("t_cfunc done");
    endtask
    task automatic t_special();
        setf(PCD_FN_TEST, PCD_FN_MCU);
        test_status_out = 1'b1;
        test_error_out = 1'b1;
        testDataOut = 1'b1;
        testDataOutEn = 1'b1;
        tick(1);
        check({pcOe[6:3], pcOut[6], pcOut[4:3], testDataIn}, 8'hBF);
        pcFunc[3] = PCD_FN_SPECIAL;
        pcFunc[4] = PCD_FN_SPECIAL;
        for (int b = 0; b < 2; b++) begin
            flashBusy = b[0];
            onBattery = b[0];
            tick(1);
            check({pcOe[4:3], pcOut[4:3]}, {2'b11, b[0], !b[0]});
        end
        // Busy on an open-drain pin pulls low; ready lets go
        pcOpenDrain[3] = 1'b1;
        tick(1);
        check({pcOe[3], pcOut[3]}, 2'b10);
        flashBusy = 1'b0;
        tick(1);
        check(pcOe[3], 1'b0);
        $display("t_special done");
    endtask
    task automatic t_pd();
        setf(PCD_FN_SPECIAL, PCD_FN_SPECIAL);
        clkPin = 1'b1;
        hm.set_sel(1'b0, 1'b0);
        tick(1);
        check({memEnable, byteValid, byte_enable_in_n, logic_clock_in}, 4'hD);
        clkPin = 1'b0;
        hm.set_sel(1'b1, 1'b1);
        tick(1);
        check({memEnable, byteValid, byte_enable_in_n, logic_clock_in}, 4'h2);
        setf(PCD_FN_MCU, PCD_FN_MCELL);
        logicChipSel = 3'h5;
        tick(1);
        check({pdOe, pdOut}, 6'h3D);
        setf(PCD_FN_MCU, PCD_FN_MCU);
        pdHostDir = 3'h3;
        pdHostOut = 3'h2;
        tick(1);
        check({pdOe, pdOut & pdOe, pdHostRead}, {6'h1A, pdIn});
        setf(PCD_FN_MCU, PCD_FN_PLDIN);
        tick(1);
        check({pdOe, pdLogicIn}, {3'h0, pdIn});
        $display("t_pd done");
    endtask
    task automatic t_addr();
        pcd_addrout_s e;
        logic [15:0] a;
        pdFunc[0] = PCD_FN_SPECIAL;
        for (int m = 0; m < 4; m++) begin
            hostMode = pcd_host_e'(m);
            a = 16'h4D2B ^ {4{m[3:0]}};
            hm.addr_phase(a, m == 1);
            tick(3);
            case (m)
                0: e = {8'hFF, a[7:0], 8'hFF, a[7:0]};
                1: e = {16'h0000, 8'hFF, a[7:0]};
                2: e = {8'hF0, a[7:4], 4'h0, 8'h0F, 4'h0, a[11:8]};
                default: e = {16'h0000, 8'hFF, a[15:8]};
            endcase
            // Except in the non-multiplexed pass, where the address is kept, the bus has turned round by now, so this also proves the hold
            check({addrDrive.oeA, addrDrive.valA & e.oeA}, {e.oeA, e.valA});
            check({addrDrive.oeB, addrDrive.valB & e.oeB}, {e.oeB, e.valB});
        end
        // Per-pin address select masks the port drive
        pbAddrSel = 8'h0F;
        tick(1);
        check(addrDrive.oeB, 8'h0F);
        $display("t_addr done");
    endtask
    // Main sequence
    initial begin
        setf(PCD_FN_MCU, PCD_FN_MCU);
        tick(16);
        rst = 1'b0;
        t_cfunc();
        t_special();
        t_pd();
        t_addr();
        print_verdict();
    end
    // Tests need about 60 cycles; 20 us is a wide margin
    initial begin
        #20000;
        failures++;
        print_verdict();
    end
endmodule
